// ---- hdl/adc_seq_ctrl.sv ----
// converter sequencing control with apb registers and one level interrupt
// assumes analog_in_channels_in come from pins; apb master on clk_in
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////
// Contract
// (RULE_01) sample the selected input for about one sixth of conversion time
// (RULE_02) channel-select write leaves the conversion-done flag untouched
// (RULE_03) channel change mid-conversion may first complete the old channel's result
// (RULE_04) software clears the done flag before restarting a stopped converter
// (RULE_05) run set under 14 us after enable marks first result suspect
// (RULE_06) run set while enable is 0 marks first result suspect
// (RULE_07) software waits for first done interrupt and discards that result
// (RULE_08) mode or channel write may leave the result register undefined
// (RULE_09) software reads the result before writing mode or channel registers
// (RULE_10) result read colliding with conversion end wins; result written afterwards
// (RULE_11) mode or channel write colliding with conversion end drops result and interrupt
// (RULE_12) mode bit 7 is run, bit 0 is enable; both clear stops converter
// (RULE_13) mode bits 5 to 3 select conversion time
// (RULE_14) each conversion end writes result, sets done flag, raises interrupt
// (RULE_15) while run is set, next conversion starts right after the previous
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // analog inputs, digitised levels per channel
    input wire logic [CHAN_N*RES_W-1:0] analog_in_channels_in,
    // converter status
    output logic conversion_done_irq_out,
    output logic sampling_out
);
    typedef struct packed {
        logic [CHAN_N*RES_W-1:0] sync1;
        logic [CHAN_N*RES_W-1:0] sync2;
        logic [7:0] mode;
        logic [CHAN_W-1:0] chan;
        logic [RES_W-1:0] result;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] irq_en;
        logic [STAB_W-1:0] stab;
        logic first_pend;
        logic first_bad;
        logic start;
        logic pend_valid;
        logic [RES_W-1:0] pend_res;
        logic [31:0] rdata;
        logic irq;
    } ctrl_t;
    ctrl_t s_q, s_d;

    logic core_busy;
    logic core_done;
    logic [RES_W-1:0] core_res;
    logic setup;
    logic wr_acc;
    logic wr_mode;
    logic wr_chan;
    logic rd_result;
    logic run_rise;
    logic abort;
    logic [CNT_W-1:0] conv_cycles;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return hit(a, MODE_OFS) || hit(a, CHAN_OFS) || hit(a, RESULT_OFS) ||
            hit(a, STATUS_OFS) || hit(a, CLEAR_OFS) || hit(a, IRQ_EN_OFS);
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign setup = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign wr_mode = wr_acc && hit(paddr_in, MODE_OFS);
    assign wr_chan = wr_acc && hit(paddr_in, CHAN_OFS);
    assign rd_result = psel_in && !pwrite_in && hit(paddr_in, RESULT_OFS);
    assign run_rise = wr_mode && pwdata_in[MODE_RUN_BIT] && !s_q.mode[MODE_RUN_BIT];
    assign abort = wr_mode || wr_chan;
    // RULE_13
    assign conv_cycles = CONV_BASE_CYCLES * (CNT_W'(s_q.mode[MODE_TSEL_HI:MODE_TSEL_LO]) + 1'b1);

    //////////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        s_d.sync1 = analog_in_channels_in;
        s_d.sync2 = s_q.sync1;
        s_d.start = 1'b0;
        // stabilisation counter runs while enable is set
        if (!s_q.mode[MODE_ENA_BIT]) begin
            s_d.stab = '0;
        end else if (s_q.stab != STAB_W'(STAB_CYCLES)) begin
            s_d.stab = s_q.stab + 1'b1;
        end
        if (wr_mode) begin
            s_d.mode = pwdata_in[7:0];
        end
        if (wr_chan) begin
            s_d.chan = pwdata_in[CHAN_W-1:0]; // RULE_02
        end
        if (wr_acc && hit(paddr_in, IRQ_EN_OFS)) begin
            s_d.irq_en = pwdata_in[ST_W-1:0];
        end
        if (wr_acc && hit(paddr_in, CLEAR_OFS)) begin
            s_d.status = s_q.status & ~pwdata_in[ST_W-1:0];
        end
        if (run_rise) begin
            s_d.first_pend = 1'b1;
            s_d.first_bad = !s_q.mode[MODE_ENA_BIT] || // RULE_06
                (s_q.stab < STAB_W'(STAB_CYCLES)); // RULE_05
        end
        // RULE_15
        if (s_q.mode[MODE_RUN_BIT] && !abort && !core_busy && !s_q.start && !core_done) begin
            s_d.start = 1'b1;
        end
        // conversion end; a colliding mode or channel write wins
        if (core_done && !abort) begin // RULE_11 RULE_03
            if (rd_result) begin
                s_d.pend_valid = 1'b1; // RULE_10
                s_d.pend_res = core_res;
            end else begin
                s_d.result = core_res; // RULE_14
                s_d.status[ST_DONE_BIT] = 1'b1;
            end
            if (s_q.first_pend) begin
                s_d.first_pend = 1'b0;
                s_d.status[ST_SUSPECT_BIT] = s_q.first_bad || s_d.status[ST_SUSPECT_BIT];
            end
        end
        if (s_q.pend_valid && !rd_result) begin
            s_d.pend_valid = 1'b0;
            if (!abort) begin
                s_d.result = s_q.pend_res; // RULE_10
                s_d.status[ST_DONE_BIT] = 1'b1;
            end
        end
        // read data is captured in the setup phase
        if (setup && !pwrite_in) begin
            unique case (1'b1)
                hit(paddr_in, MODE_OFS): s_d.rdata = {24'h000000, s_q.mode};
                hit(paddr_in, CHAN_OFS): s_d.rdata = {29'h00000000, s_q.chan};
                hit(paddr_in, RESULT_OFS): s_d.rdata = {22'h000000, s_q.result};
                hit(paddr_in, STATUS_OFS): s_d.rdata = {30'h00000000, s_q.status};
                hit(paddr_in, IRQ_EN_OFS): s_d.rdata = {30'h00000000, s_q.irq_en};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        s_d.irq = |(s_d.status & s_d.irq_en); // RULE_14
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.mode <= MODE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // converter core; a mode or channel write aborts it, restarting it only while run is set (RULE_08 leaves result as is)
    sar_core core (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(s_q.start),
        .abort_in(abort || !s_q.mode[MODE_RUN_BIT]), // RULE_12
        .cycles_in(conv_cycles),
        .sample_in(s_q.sync2[s_q.chan*RES_W +: RES_W]),
        .busy_out(core_busy),
        .sampling_out(sampling_out),
        .done_out(core_done),
        .result_out(core_res)
    );

    assign prdata_out = s_q.rdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped(paddr_in);
    assign conversion_done_irq_out = s_q.irq;

    //////////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence done_clean;
        core_done && !abort && !rd_result;
    endsequence

    a_done_result: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_14
        done_clean |=> s_q.status[ST_DONE_BIT] && s_q.result == $past(core_res))
        else $error("conversion end did not store result and flag");
    a_write_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_11
        core_done && abort && !s_q.pend_valid |=> s_q.result == $past(s_q.result))
        else $error("result updated despite colliding register write");
    a_read_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_10
        core_done && !abort && rd_result |=> s_q.result == $past(s_q.result) && s_q.pend_valid)
        else $error("result changed under a colliding read");
    a_chan_keeps_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_02
        wr_chan && s_q.status[ST_DONE_BIT] |=> s_q.status[ST_DONE_BIT])
        else $error("channel write cleared the done flag");
    a_disabled_run: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_06
        run_rise && !s_q.mode[MODE_ENA_BIT] |=> s_q.first_bad && s_q.first_pend)
        else $error("run without enable not marked suspect");
    a_early_run: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_05
        run_rise && s_q.mode[MODE_ENA_BIT] |=> s_q.first_bad == ($past(s_q.stab) < STAB_CYCLES))
        else $error("stabilisation check wrong on run");
    a_restart: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_15
        core_done && s_q.mode[MODE_RUN_BIT] && !abort ##1 !abort [*2] |-> ##0 $past(s_q.start) || s_q.start)
        else $error("next conversion not started after completion");
    a_stop_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_12
        !s_q.mode[MODE_RUN_BIT] && !s_q.mode[MODE_ENA_BIT] |=> !core_busy)
        else $error("converter busy while stopped");
    a_irq_level: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE_14
        conversion_done_irq_out == |(s_q.status & s_q.irq_en))
        else $error("interrupt does not follow enabled status");
endmodule

// ---- hdl/adc_seq_pkg.sv ----
// constants for the converter sequencing block
// assumes a 25 MHz system clock and a 32-bit apb register bus
package adc_seq_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STAB_TIME_NS = 14000;
    localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_W = 9;
    localparam int RES_W = 10;
    localparam int CHAN_N = 8;
    localparam int CHAN_W = 3;
    localparam int CNT_W = 12;
    localparam int SAMPLE_DIV = 6;
    localparam logic [CNT_W-1:0] CONV_BASE_CYCLES = 12'h024;
    // register byte offsets
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] CHAN_OFS = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] CLEAR_OFS = 8'h10;
    localparam logic [7:0] IRQ_EN_OFS = 8'h14;
    // mode register fields
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_ENA_BIT = 0;
    localparam int MODE_TSEL_LO = 3;
    localparam int MODE_TSEL_HI = 5;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // status / clear / enable layout
    localparam int ST_DONE_BIT = 0;
    localparam int ST_SUSPECT_BIT = 1;
    localparam int ST_W = 2;
endpackage

// ---- hdl/sar_core.sv ----
// successive-approximation core: one conversion per start pulse
// assumes sample value is already synchronised to clk_in
`timescale 1ns/10ps
module sar_core
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [CNT_W-1:0] cycles_in,
    input wire logic [RES_W-1:0] sample_in,
    // status and result
    output logic busy_out,
    output logic sampling_out,
    output logic done_out,
    output logic [RES_W-1:0] result_out
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] samp_end;
        logic [RES_W-1:0] held;
        logic [RES_W-1:0] res;
    } core_t;
    core_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (abort_in) begin
            s_d.busy = 1'b0;
        end else if (start_in) begin
            s_d.busy = 1'b1;
            s_d.cnt = cycles_in;
            s_d.samp_end = cycles_in - cycles_in / CNT_W'(SAMPLE_DIV);
        end else if (s_q.busy) begin
            s_d.cnt = s_q.cnt - 1'b1;
            if (s_q.cnt > s_q.samp_end) begin
                s_d.held = sample_in; // RULE_01
            end
            if (s_q.cnt == CNT_W'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.res = s_q.held;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_out = s_q.busy;
    assign sampling_out = s_q.busy && (s_q.cnt > s_q.samp_end); // RULE_01
    assign done_out = s_q.done;
    assign result_out = s_q.res;

    // an abort cuts the window short, so it stops the check
    a_sample_window: assert property (@(posedge clk_in) disable iff (sys_rst_in || abort_in) // RULE_01
        start_in && !abort_in && cycles_in == CONV_BASE_CYCLES |=> sampling_out [*6] ##1 !sampling_out)
        else $error("sampling window is not one sixth of the conversion");
endmodule

// ---- sim/analog_src_model.sv ----
// model of the eight analog sources feeding the converter
// assumes the bench pulses load_in to pick fresh random levels
`timescale 1ns/10ps
module analog_src_model
    import adc_seq_pkg::*;
(
    // clock and control
    input wire logic clk_in,
    input wire logic load_in,
    // digitised channel levels
    output logic [CHAN_N*RES_W-1:0] levels_out
);
    initial levels_out = '0;
    // levels move only on load, so a sample window sees a steady input only when load_in stays low throughout it
    always @(posedge clk_in) begin
        if (load_in) begin
            for (int k = 0; k < CHAN_N; k++) begin
                levels_out[k*RES_W +: RES_W] <= RES_W'($urandom);
            end
        end
    end
endmodule

// ---- sim/adc_sequencing_control_tb.sv ----
// self-checking bench for the converter sequencing control
// assumes zero-wait apb slave and irq enable layout equal to status
`timescale 1ns/10ps
module adc_sequencing_control_tb;
    import adc_seq_pkg::*;
    localparam int LIMIT = 20000;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic load = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, sampling;
    logic [CHAN_N*RES_W-1:0] levels;
    logic [32:0] rd_q[$];
    int wid_q[$];
    int n_mismatch = 0, compares = 0, cycles = 0, wc = 0;
    logic [CHAN_W-1:0] ch = '0;
    logic [32:0] old_res;
    ////////////////////////////////////////////////////////////////////////////////
    analog_src_model analog_src_model_inst (.clk_in(clk_in), .load_in(load), .levels_out(levels));
    adc_seq_ctrl adc_seq_ctrl_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .analog_in_channels_in(levels),
        .conversion_done_irq_out(irq), .sampling_out(sampling));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_wid(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch at %0t: sample width %0d expected %0d", $time, got, exp);
        end
    endtask
    task cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: level %b expected %b", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_on(input int n, input bit samp);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            if ((samp ? sampling : irq) === 1'b1) break;
        end
    endtask
    function automatic logic [32:0] lvl();
        return {23'h0, levels[ch*RES_W +: RES_W]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // read and sample-width monitors, timeout
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            test_done;
        end
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
            cmp_rd({pslverr, prdata}, rd_q.pop_front());
        if (sampling === 1'b1) wc <= wc + 1;
        else if (wc != 0) begin
            if (wid_q.size() > 0) cmp_wid(wc, wid_q.pop_front());
            wc <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hfdbb));
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        ch = CHAN_W'($urandom_range(7, 0));
        load <= 1'b1;
        @(posedge clk_in);
        load <= 1'b0;
        rd(MODE_OFS, 33'h0);
        rd(CHAN_OFS, 33'h0);
        rd(RESULT_OFS, 33'h0);
        rd(STATUS_OFS, 33'h0);
        rd(IRQ_EN_OFS, 33'h0);
        rd(8'h40, 33'h1_0000_0000);
        wr(IRQ_EN_OFS, 32'h1);
        wr(CHAN_OFS, {29'h0, ch});
        // run with the converter disabled
        wid_q.push_back(int'(CONV_BASE_CYCLES) / SAMPLE_DIV);
        wr(MODE_OFS, 32'h80);
        wait_on(100, 1'b0);
        cmp_bit(irq, 1'b1);
        rd(STATUS_OFS, 33'h3);
        rd(RESULT_OFS, lvl());
        wr(IRQ_EN_OFS, 32'h0);
        repeat (3) @(negedge clk_in);
        cmp_bit(irq, 1'b0);
        wr(IRQ_EN_OFS, 32'h1);
        wr(MODE_OFS, 32'h0);
        wr(CLEAR_OFS, 32'h3);
        repeat (40) @(negedge clk_in);
        cmp_bit(sampling, 1'b0);
        cmp_bit(irq, 1'b0);
        // run straight after enable
        wr(MODE_OFS, 32'h1);
        wr(MODE_OFS, 32'h81);
        wait_on(100, 1'b0);
        cmp_bit(irq, 1'b1);
        rd(STATUS_OFS, 33'h3);
        wr(MODE_OFS, 32'h1);
        wr(CLEAR_OFS, 32'h3);
        repeat (360) @(posedge clk_in);
        // every conversion time, enable long settled
        for (int t = 0; t < 8; t++) begin
            wid_q.push_back(6 * (t + 1));
            wr(MODE_OFS, 32'h81 | (t << 3));
            wait_on(36 * (t + 1) + 20, 1'b0);
            cmp_bit(irq, 1'b1);
            wait_on(10, 1'b1);
            cmp_bit(sampling, 1'b1);
            rd(STATUS_OFS, 33'h1);
            rd(RESULT_OFS, lvl());
            if (t == 7) begin
                ch = ch + 3'h1;
                wr(CHAN_OFS, {29'h0, ch});
                rd(STATUS_OFS, 33'h1);
            end
            wr(MODE_OFS, 32'h1);
            wr(CLEAR_OFS, 32'h1);
            repeat (4) @(posedge clk_in);
        end
        // channel write and result read landing on a conversion end
        wr(MODE_OFS, 32'h81);
        wait_on(100, 1'b0);
        wr(CLEAR_OFS, 32'h1);
        repeat (33) @(posedge clk_in);
        wr(CHAN_OFS, {29'h0, ch});
        old_res = lvl();
        load <= 1'b1;
        rd(STATUS_OFS, 33'h0);
        load <= 1'b0;
        cmp_bit(irq, 1'b0);
        repeat (34) @(posedge clk_in);
        rd(RESULT_OFS, old_res);
        rd(STATUS_OFS, 33'h1);
        rd(RESULT_OFS, lvl());
        test_done;
    end
endmodule
